// ===== core/ees_pkg.sv
// Constants and types shared by the serial memory slave
package ees_pkg;
	// Slave address fields
	localparam logic [3:0] DEV_TYPE   = 4'ha;
	localparam logic [2:0] SUB_ADDR   = 3'h0;
	// Array geometry
	localparam int         ADDR_W     = 12;
	localparam int         DATA_W     = 8;
	localparam int         OFS_W      = 6;
	localparam int         BASE_W     = ADDR_W - OFS_W;
	localparam int         HI_W       = ADDR_W - DATA_W;
	localparam int         PAGE_SIZE  = 64;
	localparam int         MEM_SIZE   = 4096;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	// Reset values
	localparam logic [7:0] ERASED     = 8'hff;
	localparam logic [11:0] ADDR_RST  = 12'h000;
	// Programming time
	localparam int         CLK_HZ     = 40_000_000;
	localparam int         T_WC_MS    = 5;
	localparam int         T_WC_CYCLES = T_WC_MS * (CLK_HZ / 1000);
	localparam int         PCW        = $clog2(T_WC_CYCLES);
	// Bus-side states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEVADDR,
		ST_ADDRHI,
		ST_ADDRLO,
		ST_WDATA,
		ST_RDATA,
		ST_WAITSTOP
	} ees_state_e;
endpackage

// ===== core/ees_array.sv
// Non-volatile byte array modelled as flip-flops
`timescale 1ns/10ps
module ees_array (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic                        clkEn,
	// Programming port
	input  wire logic                        we,
	input  wire logic [ees_pkg::ADDR_W-1:0]  wa,
	input  wire logic [ees_pkg::DATA_W-1:0]  wd,
	// Read port
	input  wire logic [ees_pkg::ADDR_W-1:0]  ra,
	output logic      [ees_pkg::DATA_W-1:0]  rd
);
	logic [ees_pkg::DATA_W-1:0] memFf [ees_pkg::MEM_SIZE];

	// Cells start erased after reset
	for (genvar i = 0; i < ees_pkg::MEM_SIZE; i++) begin : g_cell
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				memFf[i] <= ees_pkg::ERASED;
			end else if (clkEn && we && (wa == ees_pkg::ADDR_W'(i))) begin
				memFf[i] <= wd;
			end
		end
	end

	assign rd = memFf[ra];
endmodule

// ===== core/ees_i2c_slave.sv
// Two-wire serial slave front end with page buffer and programming timer
`timescale 1ns/10ps
// Behaviour
// - Data change with clock high means START/STOP
// - START is data fall, clock high; idle before
// - STOP is data rise, clock high; ends operations
// - Address byte upper nibble is device type 1010
// - Address LSB one reads, zero writes
// - Acknowledge only own address, then read/write
// - Receiver pulls data low on ninth clock
// - Selected writes acknowledge every received byte
// - Read: send byte, sample ack, stop on none
// - STOP after write starts programming; ignore bus
// - Up to 64 bytes committed together after STOP
// - Write increments only in-page address bits
// - Over 64 bytes wraps, overwriting buffered bytes
// - Polling: no acknowledge until programming ends
// - Counter is last address plus one, wraps
// - Sequential read sends byte per master ack
// - Reads increment the full address counter
// - Programming cycle lasts at most 5 ms
// - Supervisor reset aborts transfers, programming finishes
module ees_i2c_slave #(
	parameter int WR_CYCLES = ees_pkg::T_WC_CYCLES
) (
	// Clock, reset and enable
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic clkEn,
	// Serial bus pins
	input  wire logic sclIn,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	// Supervisor reset and status
	input  wire logic supRstIn,
	output logic      progBusy
);
	localparam logic [ees_pkg::PCW-1:0] PROG_LAST = ees_pkg::PCW'(WR_CYCLES - 1);
	localparam logic [ees_pkg::PCW-1:0] PAGE_CNT  = ees_pkg::PCW'(ees_pkg::PAGE_SIZE);

	// Synchronisers and edge history
	logic [1:0]                        sclSyncFf;
	logic [1:0]                        sdaSyncFf;
	logic [1:0]                        rstSyncFf;
	logic                              sclDlyFf;
	logic                              sdaDlyFf;
	logic                              sdaLowFf;
	logic                              sclNow;
	logic                              sdaNow;
	logic                              startDet;
	logic                              stopDet;
	logic                              sclRise;
	logic                              sclFall;
	logic                              busHold;

	// Bus-side state
	ees_pkg::ees_state_e               stateFf;
	ees_pkg::ees_state_e               nxt_state;
	logic [3:0]                        bitCntFf;
	logic [3:0]                        nxt_bitCnt;
	logic                              ackPhFf;
	logic                              nxt_ackPh;
	logic [7:0]                        shiftFf;
	logic [7:0]                        nxt_shift;
	logic                              rwFf;
	logic                              nxt_rw;
	logic                              mAckFf;
	logic                              nxt_mAck;
	logic [ees_pkg::HI_W-1:0]          hiFf;
	logic [ees_pkg::HI_W-1:0]          nxt_hi;
	logic [ees_pkg::ADDR_W-1:0]        addrCntFf;
	logic [ees_pkg::ADDR_W-1:0]        nxt_addrCnt;
	logic                              sdaOeFf;
	logic                              nxt_sdaOe;
	logic                              pendFf;
	logic                              nxt_pend;
	logic [ees_pkg::BASE_W-1:0]        pageFf;
	logic [ees_pkg::BASE_W-1:0]        nxt_page;
	logic [7:0]                        bufFf [ees_pkg::PAGE_SIZE];
	logic [7:0]                        nxt_buf [ees_pkg::PAGE_SIZE];
	logic [ees_pkg::PAGE_SIZE-1:0]     validFf;
	logic [ees_pkg::PAGE_SIZE-1:0]     nxt_valid;
	logic                              progStart;

	// Programming state
	logic                              progFf;
	logic                              nxt_prog;
	logic [ees_pkg::PCW-1:0]           progCntFf;
	logic [ees_pkg::PCW-1:0]           nxt_progCnt;
	logic                              memWe;
	logic [ees_pkg::ADDR_W-1:0]        memWa;
	logic [7:0]                        memWd;
	logic [7:0]                        memRd;
	logic [ees_pkg::OFS_W-1:0]         progOfs;

	// Pins and the supervisor reset come from other domains
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclSyncFf <= 2'h3;
			sdaSyncFf <= 2'h3;
			rstSyncFf <= 2'h0;
			sclDlyFf  <= 1'b1;
			sdaDlyFf  <= 1'b1;
			sdaLowFf  <= 1'b0;
		end else if (clkEn) begin
			sclSyncFf <= {sclSyncFf[0], sclIn};
			sdaSyncFf <= {sdaSyncFf[0], sdaIn};
			rstSyncFf <= {rstSyncFf[0], supRstIn};
			sclDlyFf  <= sclSyncFf[1];
			sdaDlyFf  <= sdaSyncFf[1];
			sdaLowFf  <= 1'b0;
		end
	end

	assign sclNow   = sclSyncFf[1];
	assign sdaNow   = sdaSyncFf[1];
	assign startDet = sclNow & sclDlyFf & sdaDlyFf & ~sdaNow;
	assign stopDet  = sclNow & sclDlyFf & ~sdaDlyFf & sdaNow;
	assign sclRise  = sclNow & ~sclDlyFf;
	assign sclFall  = ~sclNow & sclDlyFf;
	assign busHold  = rstSyncFf[1];

	// Bus-side next state
	always_comb begin
		nxt_state   = stateFf;
		nxt_bitCnt  = bitCntFf;
		nxt_ackPh   = ackPhFf;
		nxt_shift   = shiftFf;
		nxt_rw      = rwFf;
		nxt_mAck    = mAckFf;
		nxt_hi      = hiFf;
		nxt_addrCnt = addrCntFf;
		nxt_sdaOe   = sdaOeFf;
		nxt_pend    = pendFf;
		nxt_page    = pageFf;
		nxt_buf     = bufFf;
		nxt_valid   = validFf;
		progStart   = 1'b0;
		if (busHold) begin
			// Abort whatever is in flight and stay deaf
			nxt_state = ees_pkg::ST_IDLE;
			nxt_ackPh = 1'b0;
			nxt_sdaOe = 1'b0;
			nxt_pend  = 1'b0;
		end else if (startDet) begin
			// A repeated START drops an uncommitted page
			nxt_state  = ees_pkg::ST_DEVADDR;
			nxt_bitCnt = 4'h0;
			nxt_ackPh  = 1'b0;
			nxt_sdaOe  = 1'b0;
			nxt_pend   = 1'b0;
		end else if (stopDet) begin
			nxt_state = ees_pkg::ST_IDLE;
			nxt_ackPh = 1'b0;
			nxt_sdaOe = 1'b0;
			nxt_pend  = 1'b0;
			if (pendFf && !progFf) begin
				progStart = 1'b1;
			end
		end else if (stateFf != ees_pkg::ST_IDLE && stateFf != ees_pkg::ST_WAITSTOP) begin
			if (sclRise) begin
				if (ackPhFf) begin
					nxt_mAck = ~sdaNow;
				end else if (bitCntFf != ees_pkg::BYTE_BITS) begin
					nxt_shift  = {shiftFf[6:0], sdaNow};
					nxt_bitCnt = bitCntFf + 4'h1;
				end
			end else if (sclFall) begin
				if (!ackPhFf && bitCntFf == ees_pkg::BYTE_BITS) begin
					// Ninth clock: acknowledge a received byte or let go
					nxt_ackPh = 1'b1;
					nxt_sdaOe = 1'b0;
					case (stateFf)
						ees_pkg::ST_DEVADDR: begin
							if (shiftFf[7:1] == {ees_pkg::DEV_TYPE, ees_pkg::SUB_ADDR} &&
									!progFf) begin
								nxt_sdaOe = 1'b1;
								nxt_rw    = shiftFf[0];
							end else begin
								nxt_state = ees_pkg::ST_WAITSTOP;
							end
						end
						ees_pkg::ST_ADDRHI: begin
							nxt_sdaOe = 1'b1;
							nxt_hi    = shiftFf[ees_pkg::HI_W-1:0];
						end
						ees_pkg::ST_ADDRLO: begin
							nxt_sdaOe   = 1'b1;
							nxt_addrCnt = {hiFf, shiftFf};
							nxt_valid   = '0;
						end
						ees_pkg::ST_WDATA: begin
							nxt_sdaOe = 1'b1;
							nxt_buf[addrCntFf[ees_pkg::OFS_W-1:0]] = shiftFf;
							nxt_valid[addrCntFf[ees_pkg::OFS_W-1:0]] = 1'b1;
							nxt_page  = addrCntFf[ees_pkg::ADDR_W-1:ees_pkg::OFS_W];
							nxt_pend  = 1'b1;
							// Page bits hold, so the offset wraps inside the page
							nxt_addrCnt = {addrCntFf[ees_pkg::ADDR_W-1:ees_pkg::OFS_W],
								addrCntFf[ees_pkg::OFS_W-1:0] + ees_pkg::OFS_W'(1)};
						end
						default: begin
							nxt_sdaOe = 1'b0;
						end
					endcase
				end else if (ackPhFf) begin
					// End of the ninth clock
					nxt_ackPh  = 1'b0;
					nxt_bitCnt = 4'h0;
					nxt_sdaOe  = 1'b0;
					case (stateFf)
						ees_pkg::ST_DEVADDR: begin
							if (rwFf) begin
								nxt_state   = ees_pkg::ST_RDATA;
								nxt_shift   = memRd;
								nxt_sdaOe   = ~memRd[7];
								nxt_addrCnt = addrCntFf + ees_pkg::ADDR_W'(1);
							end else begin
								nxt_state = ees_pkg::ST_ADDRHI;
							end
						end
						ees_pkg::ST_ADDRHI: begin
							nxt_state = ees_pkg::ST_ADDRLO;
						end
						ees_pkg::ST_ADDRLO: begin
							nxt_state = ees_pkg::ST_WDATA;
						end
						ees_pkg::ST_RDATA: begin
							if (mAckFf) begin
								nxt_shift   = memRd;
								nxt_sdaOe   = ~memRd[7];
								nxt_addrCnt = addrCntFf + ees_pkg::ADDR_W'(1);
							end else begin
								nxt_state = ees_pkg::ST_WAITSTOP;
							end
						end
						default: begin
							nxt_state = stateFf;
						end
					endcase
				end else if (stateFf == ees_pkg::ST_RDATA && bitCntFf != 4'h0) begin
					// Open-drain: drive low only for a zero bit
					nxt_sdaOe = ~shiftFf[7];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stateFf   <= ees_pkg::ST_IDLE;
			bitCntFf  <= 4'h0;
			ackPhFf   <= 1'b0;
			shiftFf   <= 8'h00;
			rwFf      <= 1'b0;
			mAckFf    <= 1'b0;
			hiFf      <= '0;
			addrCntFf <= ees_pkg::ADDR_RST;
			sdaOeFf   <= 1'b0;
			pendFf    <= 1'b0;
			pageFf    <= '0;
			validFf   <= '0;
			for (int i = 0; i < ees_pkg::PAGE_SIZE; i++) begin
				bufFf[i] <= ees_pkg::ERASED;
			end
		end else if (clkEn) begin
			stateFf   <= nxt_state;
			bitCntFf  <= nxt_bitCnt;
			ackPhFf   <= nxt_ackPh;
			shiftFf   <= nxt_shift;
			rwFf      <= nxt_rw;
			mAckFf    <= nxt_mAck;
			hiFf      <= nxt_hi;
			addrCntFf <= nxt_addrCnt;
			sdaOeFf   <= nxt_sdaOe;
			pendFf    <= nxt_pend;
			pageFf    <= nxt_page;
			validFf   <= nxt_valid;
			bufFf     <= nxt_buf;
		end
	end

	// Programming: copy marked entries, then run out the cycle time.
	// The bus cannot reach the buffer while busy, so it needs no copy.
	assign progOfs = progCntFf[ees_pkg::OFS_W-1:0];

	always_comb begin
		nxt_prog    = progFf;
		nxt_progCnt = progCntFf;
		memWe       = 1'b0;
		memWa       = {pageFf, progOfs};
		memWd       = bufFf[progOfs];
		if (progStart) begin
			nxt_prog    = 1'b1;
			nxt_progCnt = '0;
		end else if (progFf) begin
			memWe = (progCntFf < PAGE_CNT) && validFf[progOfs];
			if (progCntFf == PROG_LAST) begin
				nxt_prog = 1'b0;
			end else begin
				nxt_progCnt = progCntFf + ees_pkg::PCW'(1);
			end
		end
	end

	// Supervisor reset does not touch this group, so a cycle completes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			progFf    <= 1'b0;
			progCntFf <= '0;
		end else if (clkEn) begin
			progFf    <= nxt_prog;
			progCntFf <= nxt_progCnt;
		end
	end

	ees_array u_array (
		.clk   (clk),
		.rstn  (rstn),
		.clkEn (clkEn),
		.we    (memWe),
		.wa    (memWa),
		.wd    (memWd),
		.ra    (addrCntFf),
		.rd    (memRd)
	);

	assign sdaOut   = sdaLowFf;
	assign sdaOe    = sdaOeFf;
	assign progBusy = progFf;
endmodule

// ===== test/ees_i2c_slave_asserts.sv
// Port assertions for the serial memory slave
`timescale 1ns/10ps
module ees_i2c_slave_asserts #(
	parameter int WR_CYCLES = 100
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	// Bus and status
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic supRstIn,
	input wire logic progBusy
);
	logic [31:0] busyCnt_ff;
	logic [3:0]  stopAge_ff;
	logic        sdaQ_ff;
	// Age saturates so a stale STOP never excuses a late programming start
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busyCnt_ff <= 32'h0000_0000;
			stopAge_ff <= 4'hf;
			sdaQ_ff    <= 1'b1;
		end else begin
			busyCnt_ff <= progBusy ? busyCnt_ff + 32'h0000_0001 : 32'h0000_0000;
			stopAge_ff <= (sclIn && sdaIn && !sdaQ_ff) ? 4'h0 :
				stopAge_ff + {3'h0, stopAge_ff != 4'hf};
			sdaQ_ff    <= sdaIn;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence sSclFell;
		$past(sclIn, 3) || $past(sclIn, 4) || $past(sclIn, 5);
	endsequence
	sequence sSupHeld;
		supRstIn [*5];
	endsequence
	a_out_low: assert property (sdaOut == 1'b0)
		else $error("data output value not low");
	a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("data drive changed with clock high");
	a_oe_after_fall: assert property ($changed(sdaOe) |-> sSclFell)
		else $error("data drive changed off the clock fall");
	a_busy_quiet: assert property (progBusy |-> !sdaOe)
		else $error("bus answered while programming");
	a_busy_exact: assert property ($fell(progBusy) |-> busyCnt_ff == 32'(WR_CYCLES))
		else $error("programming length wrong");
	a_busy_bound: assert property (progBusy |-> busyCnt_ff < 32'(WR_CYCLES))
		else $error("programming too long");
	a_busy_after_stop: assert property ($rose(progBusy) |-> stopAge_ff < 4'h8)
		else $error("programming began without STOP");
	a_sup_quiet: assert property (sSupHeld |-> !sdaOe)
		else $error("bus answered during supervisor reset");
endmodule

// ===== test/ees_i2c_master_model.sv
// Behavioural two-wire bus master
`timescale 1ns/10ps
module ees_i2c_master_model (
	// Clock
	input  wire logic clk,
	// Bus
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaDrv
);
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Also a repeated START; data rises while the clock is low, then falls while it is high
	task automatic start();
		sdaDrv = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		sdaDrv = 1'b0;
		tick(4);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sdaDrv = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(4);
		sdaDrv = 1'b1;
		tick(6);
	endtask
	// Low 5 and high 3 cycles: slave output settles before sampling
	task automatic bitIo(input logic b, output logic r);
		sdaDrv = b;
		tick(3);
		scl = 1'b1;
		tick(1);
		r = sdaWire;
		tick(2);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitIo(d[i], r);
		bitIo(1'b1, r);
		ack = !r;
	endtask
	task automatic rdByte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bitIo(1'b1, r);
			d = {d[6:0], r};
		end
		bitIo(!more, r);
	endtask
endmodule

// ===== test/test_ees_i2c_slave.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/10ps
`define MST ees_i2c_master_model_inst
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH %0t got %h want %h", $time, (a), (e)); end end
module test_ees_i2c_slave;
	localparam int WRC = 100;
	logic       clk;
	logic       rstn;
	logic       supRstIn;
	logic       scl;
	logic       mSda;
	logic       sdaOe;
	logic       sdaOut;
	logic       progBusy;
	logic       ack;
	logic [7:0] d;
	logic [7:0] bad [4] = '{8'h20, 8'ha2, 8'he1, 8'had};
	wire        sda = sdaOe ? 1'b0 : mSda;
	int         fails, checks, seed, ptr, cyc, a;
	int         refMem [4096];
	int         pend [int];
	ees_i2c_slave #(.WR_CYCLES(WRC)) ees_i2c_slave_inst (.clk(clk), .rstn(rstn), .clkEn(1'b1),
		.sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .supRstIn(supRstIn),
		.progBusy(progBusy));
	ees_i2c_master_model ees_i2c_master_model_inst (.clk(clk), .sdaWire(sda), .scl(scl),
		.sdaDrv(mSda));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic report_and_stop();
		if (fails == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic hdr(input int adr);
		`MST.start();
		`MST.wrByte(8'ha0, ack);
		`CHK(ack, 1'b1)
		`MST.wrByte({4'($random(seed)), 4'(adr >> 8)}, ack);
		`CHK(ack, 1'b1)
		`MST.wrByte(8'(adr), ack);
		`CHK(ack, 1'b1)
		ptr = adr;
	endtask
	task automatic rdSeq(input int n);
		`MST.start();
		`MST.wrByte(8'ha1, ack);
		`CHK(ack, 1'b1)
		for (int i = 0; i < n; i++) begin
			`MST.rdByte(i < n - 1, d);
			`CHK(d, 8'(refMem[ptr]))
			ptr = (ptr + 1) % 4096;
		end
		`MST.stop();
	endtask
	task automatic poll(input logic want);
		`MST.start();
		`MST.wrByte(8'ha0, ack);
		`CHK(ack, want)
		`MST.stop();
	endtask
	initial begin
		rstn = 1'b0;
		supRstIn = 1'b0;
		seed = 69701;
		foreach (refMem[i]) refMem[i] = 'hff;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(progBusy, 1'b0)
		// A byte without START is ignored
		`MST.wrByte(8'ha0, ack);
		`CHK(ack, 1'b0)
		foreach (bad[i]) begin
			`MST.start();
			`MST.wrByte(bad[i], ack);
			`CHK(ack, 1'b0)
			`MST.stop();
		end
		// Start two bytes before the page end so the offset wraps
		a = (($random(seed) & 'h3f) << 6) | 62;
		hdr(a);
		for (int i = 0; i < 66; i++) begin
			d = 8'($random(seed));
			`MST.wrByte(d, ack);
			`CHK(ack, 1'b1)
			pend[ptr] = d;
			ptr = (ptr & 'hfc0) | ((ptr + 1) & 'h3f);
		end
		`MST.stop();
		poll(1'b0);
		for (int i = 0; i < 200 && progBusy; i++) @(negedge clk);
		`CHK(progBusy, 1'b0)
		poll(1'b1);
		foreach (pend[k]) refMem[k] = pend[k];
		hdr(a & 'hfc0);
		rdSeq(70);
		hdr(4095);
		rdSeq(2);
		rdSeq(1);
		supRstIn = 1'b1;
		repeat (6) @(negedge clk);
		poll(1'b0);
		supRstIn = 1'b0;
		repeat (6) @(negedge clk);
		poll(1'b1);
		// A cycle already running must outlive the supervisor reset
		a = $random(seed) & 'hfff;
		hdr(a);
		d = 8'($random(seed));
		`MST.wrByte(d, ack);
		`CHK(ack, 1'b1)
		`MST.stop();
		refMem[a] = d;
		`CHK(progBusy, 1'b1)
		supRstIn = 1'b1;
		for (int i = 0; i < 200 && progBusy; i++) @(negedge clk);
		`CHK(progBusy, 1'b0)
		supRstIn = 1'b0;
		repeat (6) @(negedge clk);
		hdr(a);
		rdSeq(1);
		report_and_stop();
	end
endmodule
bind ees_i2c_slave ees_i2c_slave_asserts #(.WR_CYCLES(WR_CYCLES)) ees_i2c_slave_asserts_inst (
	.clk(clk), .rstn(rstn), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .supRstIn(supRstIn), .progBusy(progBusy));
